// [hw/ccd_consts.svh]
// constants for the charge comparison discriminator
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH
// register byte offsets
`define CCD_OFS_CTRL    8'h00
`define CCD_OFS_LEVEL   8'h04
`define CCD_OFS_ALPHA   8'h08
`define CCD_OFS_BETA    8'h0C
`define CCD_OFS_DELTA   8'h10
`define CCD_OFS_SCALE   8'h14
`define CCD_OFS_STATUS  8'h18
`define CCD_OFS_SLOW    8'h1C
`define CCD_OFS_FAST    8'h20
`define CCD_OFS_BASE    8'h24
`define CCD_OFS_PISO    8'h28
`define CCD_OFS_COUNT   8'h2C
// reset values
`define CCD_RST_LEVEL   16'h0100
`define CCD_RST_ALPHA   8'h05
`define CCD_RST_BETA    8'h64
`define CCD_RST_DELTA   16'h0001
`define CCD_RST_SCALE   4'h0
// field positions and counts
`define CCD_CTRL_EN     0
`define CCD_BASE_LEN    32
`define CCD_BASE_SHIFT  5
`define CCD_MA_LEN      8
`define CCD_MA_SHIFT    3
`define CCD_PISO_NUM    6
`define CCD_PISO_LEN    32
`endif

// [hw/ccd_pkg.sv]
// types for the charge comparison discriminator
package ccd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INTEG,
    ST_CORR,
    ST_DISC
  } ccd_state_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } ccd_bus_t;
endpackage : ccd_pkg

// [hw/ccd_discriminator.sv]
// neutron/gamma charge comparison discriminator with register port
// Summary of operation
// [R1] one sample per clock in; trigger pulse out when event is a neutron
// [R2] state machine starts and sequences threshold, integration, correction
// [R3] eight-sample moving average feeds the threshold detector
// [R4] threshold pulse when filtered signal crosses the programmed level
// [R5] sums built by running addition; baseline over 32 samples before start
// [R6] fast sum over samples 1..alpha, slow sum over alpha+1..beta
// [R7] each sum raises its own done flag
// [R8] correction starts only after all three done flags are present
// [R9] slow minus beta*mean, fast minus alpha*mean
// [R10] neutron when corrected slow >= delta * corrected fast
// [R11] six shift-out registers expose results serially
// [R12] corrected fast scaled by two to the power scale
// [R13] software should use beta near 100 and alpha 5 or 6
// [R14] samples arrive as 14-bit words
// [R15] mean baseline is the baseline sum shifted right by five
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.svh"
module ccd_discriminator import ccd_pkg::*; #(
  parameter int SMP_W = 14
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire ccd_bus_t    i_bus,
  input  wire logic [13:0] i_smp,
  input  wire logic        i_smp_vld,
  output logic      [31:0] o_rdata,
  output logic             o_trig_req,
  output logic             o_neutron,
  output logic             o_busy,
  output logic      [5:0]  o_piso_sdo,
  output logic             o_piso_vld
);
  // ==========================================================
  // elaboration check
  if (SMP_W != 14) begin : g_chk
    $error("sample width must be 14"); // [R14]
  end

  // ==========================================================
  // reset release
  logic rst_a_r, rst_n_r;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  // ==========================================================
  // configuration registers
  logic        en_r;
  logic [15:0] level_r, delta_r;
  logic [7:0]  alpha_r, beta_r;
  logic [3:0]  scale_r;
  logic        piso_go;
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      en_r    <= 1'b0;
      level_r <= `CCD_RST_LEVEL;
      alpha_r <= `CCD_RST_ALPHA;
      beta_r  <= `CCD_RST_BETA;
      delta_r <= `CCD_RST_DELTA;
      scale_r <= `CCD_RST_SCALE;
    end else if (i_bus.we) begin
      case (i_bus.addr)
        `CCD_OFS_CTRL:  en_r    <= i_bus.wdata[`CCD_CTRL_EN];
        `CCD_OFS_LEVEL: level_r <= i_bus.wdata[15:0];
        `CCD_OFS_ALPHA: alpha_r <= i_bus.wdata[7:0];
        `CCD_OFS_BETA:  beta_r  <= i_bus.wdata[7:0];
        `CCD_OFS_DELTA: delta_r <= i_bus.wdata[15:0];
        `CCD_OFS_SCALE: scale_r <= i_bus.wdata[3:0];
        default: ;
      endcase
    end
  end
  assign piso_go = i_bus.we && (i_bus.addr == `CCD_OFS_PISO);
  // beta must exceed alpha, else the slow window is empty
  logic cfg_ok;
  assign cfg_ok = (alpha_r != 8'h00) && (beta_r > alpha_r);

  // ==========================================================
  // moving average and baseline history
  logic [13:0] ma_buf [0:7];
  logic [13:0] bl_buf [0:31];
  logic [16:0] ma_sum_r;
  logic [18:0] bl_sum_r;
  logic [13:0] filt;
  assign filt = ma_sum_r[16:3]; // divide by eight
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int k = 0; k < `CCD_MA_LEN; k++) ma_buf[k] <= 14'h0000;
      for (int k = 0; k < `CCD_BASE_LEN; k++) bl_buf[k] <= 14'h0000;
      ma_sum_r <= 17'h00000;
      bl_sum_r <= 19'h00000;
    end else if (i_smp_vld) begin
      ma_buf[0] <= i_smp; // [R1]
      bl_buf[0] <= i_smp;
      for (int k = 1; k < `CCD_MA_LEN; k++) ma_buf[k] <= ma_buf[k-1];
      for (int k = 1; k < `CCD_BASE_LEN; k++) bl_buf[k] <= bl_buf[k-1];
      // running sums drop the oldest sample as the newest enters
      ma_sum_r <= ma_sum_r + 17'(i_smp) - 17'(ma_buf[7]); // [R3]
      bl_sum_r <= bl_sum_r + 19'(i_smp) - 19'(bl_buf[31]); // [R5]
    end
  end

  // ==========================================================
  // threshold detector: rising crossing of the level
  logic above_r, thr_pulse;
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) above_r <= 1'b0;
    else          above_r <= (16'(filt) >= level_r);
  end
  assign thr_pulse = (16'(filt) >= level_r) && !above_r; // [R4]

  // ==========================================================
  // main controller
  ccd_state_t  state_r;
  logic [7:0]  cnt_r;
  logic [31:0] fs_r, ss_r, ib_r;
  logic        f_done_r, s_done_r, b_done_r, all_done;
  logic signed [31:0] cs_r, cf_r, mean;
  logic signed [47:0] rhs;
  logic        cls;
  assign all_done = f_done_r && s_done_r && b_done_r; // [R8]
  assign mean = $signed(ib_r) >>> `CCD_BASE_SHIFT; // [R15]
  assign rhs  = 48'($signed({1'b0, delta_r})) * 48'(cf_r);
  assign cls  = 48'(cs_r) >= rhs; // [R10]

  // state sequence; threshold ignored while a pulse is processed
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) state_r <= ST_IDLE;
    else begin
      case (state_r)
        ST_IDLE:  if (en_r && cfg_ok && thr_pulse) state_r <= ST_INTEG; // [R2]
        ST_INTEG: if (all_done) state_r <= ST_CORR; // [R8]
        ST_CORR:  state_r <= ST_DISC;
        ST_DISC:  state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  // integrators and their done flags
  logic [7:0] cnt_nxt;
  assign cnt_nxt = cnt_r + 8'h01;
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r    <= 8'h00;
      fs_r     <= 32'h0000_0000;
      ss_r     <= 32'h0000_0000;
      ib_r     <= 32'h0000_0000;
      f_done_r <= 1'b0;
      s_done_r <= 1'b0;
      b_done_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      if (en_r && cfg_ok && thr_pulse) begin
        cnt_r    <= 8'h00;
        fs_r     <= 32'h0000_0000;
        ss_r     <= 32'h0000_0000;
        ib_r     <= 32'(bl_sum_r); // [R5]
        b_done_r <= 1'b1; // [R7]
        f_done_r <= 1'b0;
        s_done_r <= 1'b0;
      end
    end else if (state_r == ST_INTEG && i_smp_vld && !s_done_r) begin
      cnt_r <= cnt_nxt;
      if (cnt_nxt <= alpha_r) fs_r <= fs_r + 32'(i_smp); // [R6]
      else                    ss_r <= ss_r + 32'(i_smp); // [R6]
      if (cnt_nxt == alpha_r) f_done_r <= 1'b1; // [R7]
      if (cnt_nxt == beta_r)  s_done_r <= 1'b1; // [R7]
    end
  end

  // pedestal correction, one cycle, then discrimination
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cs_r <= 32'sh0000_0000;
      cf_r <= 32'sh0000_0000;
    end else if (state_r == ST_CORR) begin
      cs_r <= $signed(ss_r) - 32'($signed({1'b0, beta_r}) * mean); // [R9]
      // power-of-two scale lets delta stay an integer
      cf_r <= ($signed(fs_r) - 32'($signed({1'b0, alpha_r}) * mean))
              <<< scale_r; // [R12]
    end
  end

  // trigger request and class outputs
  logic [31:0] count_r;
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_trig_req <= 1'b0;
      o_neutron  <= 1'b0;
      count_r    <= 32'h0000_0000;
    end else begin
      o_trig_req <= (state_r == ST_DISC) && cls; // [R1]
      if (state_r == ST_DISC) begin
        o_neutron <= cls; // [R10]
        if (cls) count_r <= count_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) o_busy <= 1'b0;
    else          o_busy <= (state_r != ST_IDLE);
  end

  // ==========================================================
  // shift-out registers for an external analyser
  logic [31:0] piso_r [0:5];
  logic [5:0]  piso_cnt_r;
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int k = 0; k < `CCD_PISO_NUM; k++) piso_r[k] <= 32'h0000_0000;
      piso_cnt_r <= 6'h00;
      o_piso_sdo <= 6'h00;
      o_piso_vld <= 1'b0;
    end else if (state_r == ST_DISC) begin
      piso_r[0] <= ss_r; // [R11]
      piso_r[1] <= fs_r;
      piso_r[2] <= ib_r;
      piso_r[3] <= cs_r;
      piso_r[4] <= cf_r;
      piso_r[5] <= {31'h0000_0000, cls};
    end else if (piso_cnt_r != 6'h00) begin
      // msb first, all six lanes in step
      for (int k = 0; k < `CCD_PISO_NUM; k++) begin
        o_piso_sdo[k] <= piso_r[k][31];
        piso_r[k]     <= {piso_r[k][30:0], 1'b0}; // [R11]
      end
      o_piso_vld <= 1'b1;
      piso_cnt_r <= piso_cnt_r - 6'h01;
    end else begin
      o_piso_vld <= 1'b0;
      if (piso_go) piso_cnt_r <= 6'(`CCD_PISO_LEN);
    end
  end

  // ==========================================================
  // register read port, data one cycle after the strobe
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `CCD_OFS_CTRL:   rd_mux = {31'h0, en_r};
      `CCD_OFS_LEVEL:  rd_mux = {16'h0, level_r};
      `CCD_OFS_ALPHA:  rd_mux = {24'h0, alpha_r};
      `CCD_OFS_BETA:   rd_mux = {24'h0, beta_r};
      `CCD_OFS_DELTA:  rd_mux = {16'h0, delta_r};
      `CCD_OFS_SCALE:  rd_mux = {28'h0, scale_r};
      `CCD_OFS_STATUS: rd_mux = {26'h0, !cfg_ok, o_piso_vld, o_neutron,
                                 b_done_r, s_done_r, f_done_r};
      `CCD_OFS_SLOW:   rd_mux = cs_r;
      `CCD_OFS_FAST:   rd_mux = cf_r;
      `CCD_OFS_BASE:   rd_mux = ib_r;
      `CCD_OFS_PISO:   rd_mux = {26'h0, piso_cnt_r};
      `CCD_OFS_COUNT:  rd_mux = count_r;
      default:         rd_mux = 32'h0000_0000; // unmapped reads zero
    endcase
  endfunction

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r)      o_rdata <= 32'h0000_0000;
    else if (i_bus.re) o_rdata <= rd_mux(i_bus.addr);
    else               o_rdata <= 32'h0000_0000;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n_r);

  AST_TRIG_SRC: assert property ( // [R1]
    o_trig_req |-> $past(state_r) == ST_DISC && o_neutron)
    else $error("trigger without discrimination");

  AST_START: assert property ( // [R2]
    state_r == ST_IDLE && en_r && cfg_ok && thr_pulse |=> state_r == ST_INTEG)
    else $error("controller missed threshold");

  AST_MA_SUM: assert property ( // [R3]
    ma_sum_r == 17'(ma_buf[0]) + 17'(ma_buf[1]) + 17'(ma_buf[2])
      + 17'(ma_buf[3]) + 17'(ma_buf[4]) + 17'(ma_buf[5])
      + 17'(ma_buf[6]) + 17'(ma_buf[7]))
    else $error("moving average sum wrong");

  AST_THR: assert property ( // [R4]
    thr_pulse |-> 16'(filt) >= level_r && $past(16'(filt)) < $past(level_r))
    else $error("threshold pulse without crossing");

  AST_FAST_DONE: assert property ( // [R6]
    $rose(f_done_r) |-> cnt_r == alpha_r && $past(state_r) == ST_INTEG)
    else $error("fast sum ended at wrong sample");

  AST_MATCH: assert property ( // [R8]
    state_r == ST_CORR |-> $past(state_r) == ST_INTEG && $past(all_done))
    else $error("correction started early");

  AST_CORR: assert property ( // [R9]
    state_r == ST_DISC |-> cs_r == $signed(ss_r)
      - 32'($signed({1'b0, beta_r}) * ($signed(ib_r) >>> 5)))
    else $error("slow correction wrong");

  AST_CLASS: assert property ( // [R10]
    state_r == ST_DISC |=> o_neutron == ($past(48'(cs_r))
      >= 48'($signed({1'b0, $past(delta_r)})) * 48'($past(cf_r))))
    else $error("classification wrong");

  AST_PISO_LEN: assert property ( // [R11]
    piso_go && state_r != ST_DISC && piso_cnt_r == 6'h00
      |=> ##1 o_piso_vld [*8])
    else $error("shift-out too short");

endmodule : ccd_discriminator
`default_nettype wire

// [bench/ccd_trig_leaf.sv]
// trigger leaf model: stamps and counts neutron trigger requests
`timescale 1ns/1ps
`default_nettype none
module ccd_trig_leaf (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_trig_req,
  output logic      [15:0] o_req_cnt,
  output logic      [47:0] o_last_ts
);
  // ==========================================
  // timestamp and request capture
  logic [47:0] ts_r;
  // free-running stamp, one count per 10 ns cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ts_r <= 48'h0;
    end else begin
      ts_r <= ts_r + 48'h1;
    end
  end
  // a request is one high cycle; a stuck request is counted every cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_req_cnt <= 16'h0;
      o_last_ts <= 48'h0;
    end else if (i_trig_req) begin
      o_req_cnt <= o_req_cnt + 16'h1;
      o_last_ts <= ts_r;
    end
  end
endmodule : ccd_trig_leaf
`default_nettype wire

// [bench/charge_comparison_discriminator_tb_top.sv]
// self-checking bench for the charge comparison discriminator
`timescale 1ns/1ps
`default_nettype none
module charge_comparison_discriminator_tb_top import ccd_pkg::*; ;
  // ==========================================
  // signals
  logic        clk = 1'b0;
  logic        arst_n;
  ccd_bus_t    bus;
  logic [13:0] smp;
  logic [13:0] lvl;
  logic        smp_vld;
  logic [31:0] rdata;
  logic [31:0] rd_d;
  logic        trig;
  logic        neutron;
  logic        busy;
  logic [5:0]  sdo;
  logic        piso_vld;
  logic [15:0] req_cnt;
  logic [15:0] exp_cnt;
  int          error_cnt;
  int          n_tests;
  logic [7:0]  a_tab [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h30};
  logic [31:0] v_tab [8] = '{32'h0, 32'h100, 32'h5, 32'h64, 32'h1, 32'h0, 32'h0, 32'h0};

  ccd_discriminator ccd_discriminator_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_bus(bus), .i_smp(smp), .i_smp_vld(smp_vld),
    .o_rdata(rdata), .o_trig_req(trig), .o_neutron(neutron), .o_busy(busy),
    .o_piso_sdo(sdo), .o_piso_vld(piso_vld));
  ccd_trig_leaf ccd_trig_leaf_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_trig_req(trig), .o_req_cnt(req_cnt), .o_last_ts());

  // ==========================================
  // clock and sample stream
  always #5 clk = ~clk;
  // one 14-bit sample every cycle, level set by the scenario tasks
  always @(posedge clk) begin
    smp <= lvl;
  end

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic timeout;
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : timeout
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge clk);
    bus.we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge clk);
    bus.re <= 1'b0;
    #1 rd_d = rdata;
  endtask : rd

  // ==========================================
  // scenarios
  // reset values, read-only status and an unmapped place
  task automatic reset_values;
    wr(8'h30, 32'hFFFF_FFFF);
    wr(8'h18, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      rd(a_tab[i]);
      chk(rd_d, v_tab[i], "register after reset");
    end
  endtask : reset_values
  // a pulse that must not start the controller
  task automatic idle_check(input logic [13:0] v, input int len, input string what);
    logic seen;
    seen = 1'b0;
    @(posedge clk) lvl <= v;
    // the restore edge below lets one more sample through, so hold one cycle less
    repeat (len - 1) begin
      @(posedge clk);
      #1 seen = seen | busy;
    end
    @(posedge clk) lvl <= 14'd64;
    repeat (40) begin
      @(posedge clk);
      #1 seen = seen | busy;
    end
    chk({31'h0, seen}, 32'h0, what);
  endtask : idle_check
  // step 64 -> 74: mean 64 whatever edge samples the window holds, cs 630, cf 50
  task automatic run_event(input logic [15:0] d, input logic [3:0] sc, input logic exp_n);
    int k;
    int n_trig;
    int lat;
    k = 0;
    n_trig = 0;
    lat = 0;
    wr(8'h10, {16'h0, d});
    wr(8'h14, {28'h0, sc});
    @(posedge clk) lvl <= 14'd74;
    while (busy !== 1'b1) begin
      @(posedge clk);
      #1 k++;
      if (k > 20) timeout();
    end
    for (k = 1; k <= 130; k++) begin
      @(posedge clk);
      #1 if (trig === 1'b1) begin
        n_trig++;
        lat = k;
      end
    end
    if (exp_n) exp_cnt++;
    chk(32'(n_trig), {31'h0, exp_n}, "trigger pulses");
    if (exp_n) chk({31'h0, lat >= 99 && lat <= 106}, 32'h1, "trigger latency");
    chk({31'h0, busy}, 32'h0, "busy after decision");
    chk({31'h0, neutron}, {31'h0, exp_n}, "class");
    @(posedge clk) lvl <= 14'd64;
    repeat (45) @(posedge clk);
    rd(8'h1C);
    chk(rd_d, 32'd630, "corrected slow");
    rd(8'h20);
    chk(rd_d, 32'd50 << sc, "corrected fast");
    // 31 samples of 64 plus the first 74 sit in the window at the crossing edge
    rd(8'h24);
    chk(rd_d, 32'd2058, "baseline sum");
    rd(8'h18);
    chk(rd_d, {28'h0, exp_n, 3'h7}, "status");
    rd(8'h2C);
    chk(rd_d, {16'h0, exp_cnt}, "neutron count");
    chk({16'h0, req_cnt}, {16'h0, exp_cnt}, "leaf count");
  endtask : run_event
  // all six serial lanes, msb first, 32 cycles
  task automatic shift_check;
    logic [31:0] ln [6];
    int k;
    foreach (ln[j]) ln[j] = 32'h0;
    k = 0;
    wr(8'h28, 32'h1);
    #1;
    while (piso_vld !== 1'b1) begin
      @(posedge clk);
      #1 k++;
      if (k > 4) timeout();
    end
    repeat (32) begin
      for (int j = 0; j < 6; j++) ln[j] = {ln[j][30:0], sdo[j]};
      @(posedge clk);
      #1;
    end
    chk(ln[0], 32'd7030, "serial raw slow");
    chk(ln[1], 32'd370, "serial raw fast");
    chk(ln[2], 32'd2058, "serial baseline");
    chk(ln[3], 32'd630, "serial slow");
    chk(ln[4], 32'd50, "serial fast");
    chk(ln[5], 32'h1, "serial class");
    chk({31'h0, piso_vld}, 32'h0, "serial end");
  endtask : shift_check

  // ==========================================
  // main sequence
  initial begin
    error_cnt = 0;
    n_tests = 0;
    exp_cnt = 16'h0;
    arst_n = 1'b0;
    bus = '0;
    lvl = 14'd64;
    smp_vld = 1'b1;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    reset_values();
    wr(8'h04, 32'd65);
    wr(8'h08, 32'd5);
    wr(8'h0C, 32'd100);
    wr(8'h00, 32'h1);
    repeat (45) @(posedge clk);
    // raw 70 crosses 65, the eight-sample mean 64 does not
    idle_check(14'd70, 1, "isolated spike");
    run_event(16'd12, 4'h0, 1'b1);
    shift_check();
    run_event(16'd13, 4'h0, 1'b0);
    run_event(16'd6, 4'h1, 1'b1);
    run_event(16'd7, 4'h1, 1'b0);
    wr(8'h00, 32'h0);
    idle_check(14'd74, 30, "disabled start");
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h0);
    idle_check(14'd74, 30, "bad config start");
    tally_and_finish();
  end
endmodule : charge_comparison_discriminator_tb_top
`default_nettype wire
